// ---- rtl/fsp_pkg.sv ----
// Purpose: Shared constants and types for the flash and serial PROM port.
// Assumes: A single 20 MHz clock drives the whole block.
// Notes:   Counts are derived from times in nanoseconds and rounded up.
package fsp_pkg;
  localparam int        CLK_MHZ          = 20;
  localparam int        FLASH_ADDR_W     = 17;
  localparam int        FLASH_DATA_W     = 8;
  localparam int        PROM_ADDR_W      = 6;
  localparam int        PROM_DATA_W      = 16;
  localparam int        PROM_WORDS       = 64;
  localparam int        PROM_CMD_BITS    = 9;
  localparam int        PROM_FRAME_BITS  = PROM_CMD_BITS + PROM_DATA_W;
  localparam logic [2:0] PROM_READ_CMD   = 3'h6;
  localparam int        FLASH_SETUP_NS   = 50;
  localparam int        FLASH_STROBE_NS  = 150;
  localparam int        FLASH_HOLD_NS    = 50;
  localparam int        PROM_HALF_NS     = 500;
  localparam int        PROM_DESEL_NS    = 500;
  localparam int        PIN_CLK_SEL      = 7;
  localparam int        PIN_AUX_PWR      = 1;
  localparam int        PIN_PROM_SK      = 15;
  localparam int        PIN_PROM_DO      = 14;
  localparam int        PIN_PROM_DI      = 13;
  localparam int        PIN_AUX_CLK      = 16;

  // Least time in cycles, rounded up and never below one cycle.
  function automatic logic [7:0] cycles_ceil(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    if (c < 1) begin
      c = 1;
    end
    return c[7:0];
  endfunction

  localparam logic [7:0] FLASH_SETUP_CYC  = cycles_ceil(FLASH_SETUP_NS);
  localparam logic [7:0] FLASH_STROBE_CYC = cycles_ceil(FLASH_STROBE_NS);
  localparam logic [7:0] FLASH_HOLD_CYC   = cycles_ceil(FLASH_HOLD_NS);
  localparam logic [7:0] PROM_HALF_CYC    = cycles_ceil(PROM_HALF_NS);
  localparam logic [7:0] PROM_DESEL_CYC   = cycles_ceil(PROM_DESEL_NS);
  localparam logic [4:0] PROM_LAST_BIT    = 5'(PROM_FRAME_BITS - 1);
  localparam logic [5:0] PROM_LAST_WORD   = 6'(PROM_WORDS - 1);

  typedef enum logic [1:0] {OWN_IDLE, OWN_FLASH, OWN_PROM} fsp_owner_type;
  typedef enum logic [1:0] {FL_IDLE, FL_SETUP, FL_STROBE, FL_HOLD} fsp_fl_state_type;
  typedef enum logic [2:0] {PR_IDLE, PR_SELECT, PR_LOW, PR_HIGH, PR_DESEL} fsp_pr_state_type;
endpackage

// ---- rtl/fsp_if.sv ----
// Purpose: Carriers between the port controller and its two sequencers.
// Assumes: All signals belong to the one clock domain.
// Notes:   The ctl side starts a cycle; the seq side runs it and drives pins.
`timescale 1ns/100ps
`default_nettype none
interface fsp_flash_if;
  logic                               start;
  logic                               write;
  logic [fsp_pkg::FLASH_ADDR_W-1:0]   addr;
  logic [fsp_pkg::FLASH_DATA_W-1:0]   wdata;
  logic [fsp_pkg::FLASH_DATA_W-1:0]   pin_data;
  logic                               done;
  logic [fsp_pkg::FLASH_DATA_W-1:0]   rdata;
  logic [fsp_pkg::FLASH_ADDR_W-1:0]   addr_out;
  logic [fsp_pkg::FLASH_DATA_W-1:0]   data_out;
  logic                               data_oe;
  logic                               cs_n;
  logic                               oe_n;
  logic                               we_n;
  modport seq (input start, write, addr, wdata, pin_data,
               output done, rdata, addr_out, data_out, data_oe, cs_n, oe_n, we_n);
  modport ctl (output start, write, addr, wdata, pin_data,
               input done, rdata, addr_out, data_out, data_oe, cs_n, oe_n, we_n);
endinterface

interface fsp_prom_if;
  logic                              start;
  logic                              do_in;
  logic                              done;
  logic                              word_valid;
  logic [fsp_pkg::PROM_ADDR_W-1:0]   word_index;
  logic [fsp_pkg::PROM_DATA_W-1:0]   word_data;
  logic                              sk;
  logic                              di;
  logic                              cs;
  modport seq (input start, do_in,
               output done, word_valid, word_index, word_data, sk, di, cs);
  modport ctl (output start, do_in,
               input done, word_valid, word_index, word_data, sk, di, cs);
endinterface
`default_nettype wire

// ---- rtl/fsp_flash_seq.sv ----
// Purpose: Runs one parallel flash read or write cycle.
// Assumes: Start is given only while the sequencer is idle.
// Notes:   Address and select lead and trail the strobe by fixed counts.
`timescale 1ns/100ps
`default_nettype none
module fsp_flash_seq (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  fsp_flash_if.seq fl
);
  import fsp_pkg::*;

  fsp_fl_state_type          state, next_state;
  logic [7:0]                cnt, next_cnt;
  logic                      wr, next_wr;
  logic [FLASH_ADDR_W-1:0]   addr, next_addr;
  logic [FLASH_DATA_W-1:0]   wdata, next_wdata;
  logic [FLASH_DATA_W-1:0]   rdata, next_rdata;
  logic                      done, next_done;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_wr    = wr;
    next_addr  = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_done  = 1'b0;
    case (state)
      FL_IDLE: begin
        if (fl.start) begin
          next_state = FL_SETUP;
          next_cnt   = FLASH_SETUP_CYC;
          next_wr    = fl.write;
          next_addr  = fl.addr;
          next_wdata = fl.wdata;
        end
      end
      FL_SETUP: begin
        if (cnt == 8'h01) begin
          next_state = FL_STROBE;
          next_cnt   = FLASH_STROBE_CYC;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      FL_STROBE: begin
        if (cnt == 8'h01) begin
          next_state = FL_HOLD;
          next_cnt   = FLASH_HOLD_CYC;
          if (!wr) begin
            next_rdata = fl.pin_data;
          end
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      FL_HOLD: begin
        if (cnt == 8'h01) begin
          next_state = FL_IDLE;
          next_done  = 1'b1;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      default: next_state = FL_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= FL_IDLE;
      cnt   <= 8'h00;
      wr    <= 1'b0;
      addr  <= '0;
      wdata <= '0;
      rdata <= '0;
      done  <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      cnt   <= next_cnt;
      wr    <= next_wr;
      addr  <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      done  <= next_done;
    end
  end

  assign fl.done     = done;
  assign fl.rdata    = rdata;
  assign fl.addr_out = addr;
  assign fl.data_out = wdata;
  assign fl.data_oe  = wr && (state != FL_IDLE);
  assign fl.cs_n     = (state == FL_IDLE);
  assign fl.oe_n     = !((state == FL_STROBE) && !wr);
  assign fl.we_n     = !((state == FL_STROBE) && wr);
endmodule // fsp_flash_seq
`default_nettype wire

// ---- rtl/fsp_prom_seq.sv ----
// Purpose: Reads every word of the serial PROM after a start.
// Assumes: The PROM takes a start bit, a two-bit read code and a word address.
// Notes:   Data is sampled at the end of each shift clock high phase.
`timescale 1ns/100ps
`default_nettype none
module fsp_prom_seq (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  fsp_prom_if.seq  pr
);
  import fsp_pkg::*;

  fsp_pr_state_type         state, next_state;
  logic [7:0]               cnt, next_cnt;
  logic [4:0]               bitn, next_bitn;
  logic [PROM_ADDR_W-1:0]   word, next_word;
  logic [PROM_DATA_W-1:0]   shreg, next_shreg;
  logic                     valid, next_valid;
  logic                     done, next_done;
  logic [PROM_CMD_BITS-1:0] cmd;

  assign cmd = {PROM_READ_CMD, word};

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_bitn  = bitn;
    next_word  = word;
    next_shreg = shreg;
    next_valid = 1'b0;
    next_done  = 1'b0;
    case (state)
      PR_IDLE: begin
        if (pr.start) begin
          next_state = PR_SELECT;
          next_cnt   = PROM_HALF_CYC;
          next_word  = '0;
        end
      end
      PR_SELECT: begin
        if (cnt == 8'h01) begin
          next_state = PR_LOW;
          next_cnt   = PROM_HALF_CYC;
          next_bitn  = 5'h00;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      PR_LOW: begin
        if (cnt == 8'h01) begin
          next_state = PR_HIGH;
          next_cnt   = PROM_HALF_CYC;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      PR_HIGH: begin
        if (cnt == 8'h01) begin
          next_cnt = PROM_HALF_CYC;
          if (bitn >= 5'(PROM_CMD_BITS)) begin
            next_shreg = {shreg[PROM_DATA_W-2:0], pr.do_in};
          end
          if (bitn == PROM_LAST_BIT) begin
            next_state = PR_DESEL;
            next_cnt   = PROM_DESEL_CYC;
            next_valid = 1'b1;
          end else begin
            next_state = PR_LOW;
            next_bitn  = bitn + 5'h01;
          end
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      PR_DESEL: begin
        if (cnt == 8'h01) begin
          if (word == PROM_LAST_WORD) begin
            next_state = PR_IDLE;
            next_done  = 1'b1;
          end else begin
            next_state = PR_SELECT;
            next_cnt   = PROM_HALF_CYC;
            next_word  = word + 6'h01;
          end
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      default: next_state = PR_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= PR_IDLE;
      cnt   <= 8'h00;
      bitn  <= 5'h00;
      word  <= '0;
      shreg <= '0;
      valid <= 1'b0;
      done  <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      cnt   <= next_cnt;
      bitn  <= next_bitn;
      word  <= next_word;
      shreg <= next_shreg;
      valid <= next_valid;
      done  <= next_done;
    end
  end

  assign pr.done       = done;
  assign pr.word_valid = valid;
  assign pr.word_index = word;
  assign pr.word_data  = shreg;
  assign pr.sk         = (state == PR_HIGH);
  assign pr.di         = ((state == PR_LOW) || (state == PR_HIGH)) &&
                         (bitn < 5'(PROM_CMD_BITS)) &&
                         cmd[4'(PROM_CMD_BITS - 1) - bitn[3:0]];
  assign pr.cs         = (state != PR_IDLE) && (state != PR_DESEL);
endmodule // fsp_prom_seq
`default_nettype wire

// ---- rtl/fsp_top.sv ----
// Purpose: Local memory port: byte-wide flash and serial PROM on shared pins.
// Assumes: Inputs are synchronous to CLK; straps settle while RST is high.
// Notes:   Two address pins are read as straps in reset; four pins (13 to 16) are muxed.
`timescale 1ns/100ps
`default_nettype none
module fsp_top (
  input  wire logic                                CLK,
  input  wire logic                                RST,
  input  wire logic                                CE,
  input  wire logic                                POWERUP_RESET_N,
  input  wire logic                                ISOLATE_N,
  input  wire logic                                OSC25,
  input  wire logic                                FLASH_REQ,
  input  wire logic                                FLASH_WRITE,
  input  wire logic [fsp_pkg::FLASH_ADDR_W-1:0]    FLASH_ADDR,
  input  wire logic [fsp_pkg::FLASH_DATA_W-1:0]    FLASH_WDATA,
  output var  logic                                FLASH_ACK,
  output var  logic [fsp_pkg::FLASH_DATA_W-1:0]    FLASH_RDATA,
  output var  logic                                INIT_WORD_VALID,
  output var  logic [fsp_pkg::PROM_ADDR_W-1:0]     INIT_WORD_INDEX,
  output var  logic [fsp_pkg::PROM_DATA_W-1:0]     INIT_WORD_DATA,
  output var  logic                                INIT_DONE,
  output var  logic                                CLOCK_SELECT_STRAP,
  output var  logic                                AUX_POWER_STRAP,
  input  wire logic                                FLA7_IN,
  input  wire logic                                FLA1_IN,
  input  wire logic                                FLA14_IN,
  output var  logic [fsp_pkg::FLASH_ADDR_W-1:0]    FLASH_ADDR_BUS,
  output var  logic [fsp_pkg::FLASH_ADDR_W-1:0]    FLASH_ADDR_BUS_OE,
  input  wire logic [fsp_pkg::FLASH_DATA_W-1:0]    FLASH_DATA_BUS_IN,
  output var  logic [fsp_pkg::FLASH_DATA_W-1:0]    FLASH_DATA_BUS,
  output var  logic                                FLASH_DATA_BUS_OE,
  output var  logic                                SERIAL_PROM_SELECT,
  output var  logic                                FLASH_SELECT_N,
  output var  logic                                FLASH_READ_STROBE_N,
  output var  logic                                FLASH_WRITE_STROBE_N
);
  import fsp_pkg::*;

  fsp_flash_if fl ();
  fsp_prom_if  pr ();

  logic                     any_reset;
  logic                     seq_reset;
  fsp_owner_type            owner, next_owner;
  logic                     init_pending, next_init_pending;
  logic                     init_done, next_init_done;
  logic                     clk_strap, next_clk_strap;
  logic                     aux_strap, next_aux_strap;
  logic                     fl_start;
  logic                     pr_start;
  logic [FLASH_ADDR_W-1:0]  pin_addr, next_pin_addr;
  logic [FLASH_ADDR_W-1:0]  pin_addr_oe, next_pin_addr_oe;
  logic [FLASH_DATA_W-1:0]  pin_data, next_pin_data;
  logic                     pin_data_oe, next_pin_data_oe;
  logic                     pin_prom_cs, next_pin_prom_cs;
  logic                     pin_fl_cs_n, next_pin_fl_cs_n;
  logic                     pin_fl_oe_n, next_pin_fl_oe_n;
  logic                     pin_fl_we_n, next_pin_fl_we_n;

  // Isolation holds the port quiet like a reset and reloads on release.
  assign any_reset = RST || !POWERUP_RESET_N;
  assign seq_reset = any_reset || !ISOLATE_N;

  assign fl.start    = fl_start;
  assign fl.write    = FLASH_WRITE;
  assign fl.addr     = FLASH_ADDR;
  assign fl.wdata    = FLASH_WDATA;
  assign fl.pin_data = FLASH_DATA_BUS_IN;
  assign pr.start    = pr_start;
  assign pr.do_in    = FLA14_IN;

  fsp_flash_seq u_flash (
    .clk (CLK),
    .rst (seq_reset),
    .ce  (CE),
    .fl  (fl)
  );

  fsp_prom_seq u_prom (
    .clk (CLK),
    .rst (seq_reset),
    .ce  (CE),
    .pr  (pr)
  );

  // Owner arbitration: one sequencer at a time, PROM load before any flash.
  always_comb begin
    next_owner        = owner;
    next_init_pending = init_pending;
    next_init_done    = init_done;
    fl_start          = 1'b0;
    pr_start          = 1'b0;
    case (owner)
      OWN_IDLE: begin
        if (init_pending) begin
          pr_start          = 1'b1;
          next_owner        = OWN_PROM;
          next_init_pending = 1'b0;
        end else if (FLASH_REQ && init_done) begin
          fl_start   = 1'b1;
          next_owner = OWN_FLASH;
        end
      end
      OWN_PROM: begin
        if (pr.done) begin
          next_owner     = OWN_IDLE;
          next_init_done = 1'b1;
        end
      end
      OWN_FLASH: begin
        if (fl.done) begin
          next_owner = OWN_IDLE;
        end
      end
      default: next_owner = OWN_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (seq_reset) begin
      owner        <= OWN_IDLE;
      init_pending <= 1'b1;
      init_done    <= 1'b0;
    end else if (CE) begin
      owner        <= next_owner;
      init_pending <= next_init_pending;
      init_done    <= next_init_done;
    end
  end

  // Straps follow their pins for as long as the bus reset is held.
  always_comb begin
    next_clk_strap = clk_strap;
    next_aux_strap = aux_strap;
    if (RST) begin
      next_clk_strap = FLA7_IN;
      next_aux_strap = FLA1_IN;
    end
  end

  always_ff @(posedge CLK) begin
    if (CE) begin
      clk_strap <= next_clk_strap;
      aux_strap <= next_aux_strap;
    end
  end

  // Pin multiplexer; every pad output is registered.
  always_comb begin
    next_pin_addr    = '0;
    next_pin_addr_oe = '1;
    next_pin_data    = fl.data_out;
    next_pin_data_oe = fl.data_oe;
    next_pin_prom_cs = pr.cs;
    next_pin_fl_cs_n = fl.cs_n;
    next_pin_fl_oe_n = fl.oe_n;
    next_pin_fl_we_n = fl.we_n;
    if (owner == OWN_FLASH) begin
      next_pin_addr = fl.addr_out;
    end else if (owner == OWN_PROM) begin
      next_pin_addr[PIN_PROM_SK]    = pr.sk;
      next_pin_addr[PIN_PROM_DI]    = pr.di;
      next_pin_addr_oe[PIN_PROM_DO] = 1'b0;
    end
    if (clk_strap) begin
      next_pin_addr[PIN_AUX_CLK] = OSC25;
    end
    if (seq_reset) begin
      next_pin_addr_oe = '0;
      next_pin_data_oe = 1'b0;
      next_pin_prom_cs = 1'b0;
      next_pin_fl_cs_n = 1'b1;
      next_pin_fl_oe_n = 1'b1;
      next_pin_fl_we_n = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_addr    <= '0;
      pin_addr_oe <= '0;
      pin_data    <= '0;
      pin_data_oe <= 1'b0;
      pin_prom_cs <= 1'b0;
      pin_fl_cs_n <= 1'b1;
      pin_fl_oe_n <= 1'b1;
      pin_fl_we_n <= 1'b1;
    end else if (CE) begin
      pin_addr    <= next_pin_addr;
      pin_addr_oe <= next_pin_addr_oe;
      pin_data    <= next_pin_data;
      pin_data_oe <= next_pin_data_oe;
      pin_prom_cs <= next_pin_prom_cs;
      pin_fl_cs_n <= next_pin_fl_cs_n;
      pin_fl_oe_n <= next_pin_fl_oe_n;
      pin_fl_we_n <= next_pin_fl_we_n;
    end
  end

  assign FLASH_ACK            = fl.done;
  assign FLASH_RDATA          = fl.rdata;
  assign INIT_WORD_VALID      = pr.word_valid;
  assign INIT_WORD_INDEX      = pr.word_index;
  assign INIT_WORD_DATA       = pr.word_data;
  assign INIT_DONE            = init_done;
  assign CLOCK_SELECT_STRAP   = clk_strap;
  assign AUX_POWER_STRAP      = aux_strap;
  assign FLASH_ADDR_BUS       = pin_addr;
  assign FLASH_ADDR_BUS_OE    = pin_addr_oe;
  assign FLASH_DATA_BUS       = pin_data;
  assign FLASH_DATA_BUS_OE    = pin_data_oe;
  assign SERIAL_PROM_SELECT   = pin_prom_cs;
  assign FLASH_SELECT_N       = pin_fl_cs_n;
  assign FLASH_READ_STROBE_N  = pin_fl_oe_n;
  assign FLASH_WRITE_STROBE_N = pin_fl_we_n;
endmodule // fsp_top
`default_nettype wire

// ---- sim/fsp_partner.sv ----
// Purpose: Flash chip and serial PROM models on the far side of the pins.
// Assumes: The PROM answers only to the read code; other codes give ones.
// Notes: Released lines show the inverse of their last value.
`timescale 1ns/100ps
`default_nettype none
module fsp_partner (
  input  wire logic        cs_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  data,
  output var  logic [7:0]  q,
  input  wire logic        sel,
  input  wire logic        sk,
  input  wire logic        di,
  output var  logic        dout
);
  import fsp_pkg::*;
  logic [7:0]  mem [0:131071];
  logic [4:0]  n = 5'h00;
  logic [2:0]  c;
  logic [5:0]  a;
  logic [15:0] w;
  initial q = 8'h00;
  initial dout = 1'h0;
  always @(posedge we_n) if (!cs_n) mem[addr] = data;
  always @(cs_n, oe_n, addr) q = (!cs_n && !oe_n) ? mem[addr] : ~q;
  always @(posedge sk or negedge sel) begin
    if (!sel) begin
      n <= 5'h00;
      dout <= ~dout;
    end else begin
      n <= n + 5'h01;
      if (n < 5'h03) c <= {c[1:0], di};
      if (n > 5'h02 && n < 5'h09) a <= {a[4:0], di};
      if (n == 5'h08) w <= (c == PROM_READ_CMD) ? {4'hA, a[4:0], di, ~a[4:0], ~di} : 16'hFFFF;
      if (n > 5'h08 && n < 5'h19) dout <= w[5'h18 - n];
    end
  end
endmodule // fsp_partner
`default_nettype wire

// ---- sim/fsp_top_checker.sv ----
// Purpose: Pin level checks of the flash and PROM port.
// Assumes: CE stays high.
// Notes: Attached to every fsp_top by bind.
`timescale 1ns/100ps
`default_nettype none
module fsp_top_checker (
  input wire logic                           CLK,
  input wire logic                           RST,
  input wire logic                           POWERUP_RESET_N,
  input wire logic                           FLA7_IN,
  input wire logic                           FLA1_IN,
  input wire logic                           CLOCK_SELECT_STRAP,
  input wire logic                           AUX_POWER_STRAP,
  input wire logic [fsp_pkg::FLASH_ADDR_W-1:0] FLASH_ADDR_BUS_OE,
  input wire logic                           FLASH_DATA_BUS_OE,
  input wire logic                           SERIAL_PROM_SELECT,
  input wire logic                           FLASH_SELECT_N,
  input wire logic                           FLASH_READ_STROBE_N,
  input wire logic                           FLASH_WRITE_STROBE_N
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  property p_excl; !(!FLASH_SELECT_N && SERIAL_PROM_SELECT); endproperty
  a_excl: assert property (p_excl) else $error("flash and prom both selected");
  property p_read;
    !FLASH_READ_STROBE_N |-> FLASH_WRITE_STROBE_N && !FLASH_SELECT_N && !FLASH_DATA_BUS_OE;
  endproperty
  a_read: assert property (p_read) else $error("bad read cycle");
  property p_write;
    !FLASH_WRITE_STROBE_N |-> FLASH_READ_STROBE_N && !FLASH_SELECT_N && FLASH_DATA_BUS_OE;
  endproperty
  a_write: assert property (p_write) else $error("bad write cycle");
  property p_wr_len;
    $fell(FLASH_WRITE_STROBE_N) |-> !FLASH_WRITE_STROBE_N [*3] ##1 FLASH_WRITE_STROBE_N;
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe length");
  property p_sel_len; $fell(FLASH_SELECT_N) |-> !FLASH_SELECT_N [*5] ##1 FLASH_SELECT_N; endproperty
  a_sel_len: assert property (p_sel_len) else $error("flash select length");
  property p_fl_pins; !FLASH_SELECT_N |-> &FLASH_ADDR_BUS_OE; endproperty
  a_fl_pins: assert property (p_fl_pins) else $error("address pin released");
  property p_pr_pins;
    SERIAL_PROM_SELECT |-> FLASH_ADDR_BUS_OE[15] && FLASH_ADDR_BUS_OE[13] && !FLASH_ADDR_BUS_OE[14];
  endproperty
  a_pr_pins: assert property (p_pr_pins) else $error("prom pin direction");
  property p_rst_idle;
    disable iff (!POWERUP_RESET_N)
    RST |=> FLASH_ADDR_BUS_OE == '0 && !FLASH_DATA_BUS_OE && FLASH_SELECT_N && !SERIAL_PROM_SELECT;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("pins driven in reset");
  property p_strap;
    disable iff (!POWERUP_RESET_N)
    RST |=> CLOCK_SELECT_STRAP == $past(FLA7_IN) && AUX_POWER_STRAP == $past(FLA1_IN);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not sampled");
  property p_hold;
    !$past(RST) |-> $stable(CLOCK_SELECT_STRAP) && $stable(AUX_POWER_STRAP);
  endproperty
  a_hold: assert property (p_hold) else $error("strap moved");
endmodule // fsp_top_checker
bind fsp_top fsp_top_checker u_chk (.CLK, .RST, .POWERUP_RESET_N, .FLA7_IN, .FLA1_IN,
  .CLOCK_SELECT_STRAP, .AUX_POWER_STRAP, .FLASH_ADDR_BUS_OE, .FLASH_DATA_BUS_OE,
  .SERIAL_PROM_SELECT, .FLASH_SELECT_N, .FLASH_READ_STROBE_N, .FLASH_WRITE_STROBE_N);
`default_nettype wire

// ---- sim/fsp_top_tb.sv ----
// Purpose: Self-checking bench of the flash and PROM port.
// Assumes: A floating strap reads as its pull, strap7 or strap1.
// Notes: One full PROM load takes about 33000 cycles.
`timescale 1ns/100ps
`default_nettype none
module fsp_top_tb;
  import fsp_pkg::*;
  logic CLK = 1'h0, RST = 1'h1, CE = 1'h1, POWERUP_RESET_N = 1'h1, ISOLATE_N = 1'h1;
  logic OSC25 = 1'h0, FLASH_REQ = 1'h0, FLASH_WRITE = 1'h0, strap7 = 1'h0, strap1 = 1'h1;
  logic [16:0] FLASH_ADDR = '0, FLASH_ADDR_BUS, FLASH_ADDR_BUS_OE;
  logic [7:0]  FLASH_WDATA = '0, FLASH_RDATA, FLASH_DATA_BUS, FLASH_DATA_BUS_IN, flash_q;
  logic [5:0]  INIT_WORD_INDEX;
  logic [15:0] INIT_WORD_DATA;
  logic FLASH_ACK, INIT_WORD_VALID, INIT_DONE, CLOCK_SELECT_STRAP, AUX_POWER_STRAP;
  logic FLASH_DATA_BUS_OE, SERIAL_PROM_SELECT, FLASH_SELECT_N, FLASH_READ_STROBE_N;
  logic FLASH_WRITE_STROBE_N, FLA7_IN, FLA1_IN, FLA14_IN, prom_do;
  int   failures = 0, n_compared = 0;
  assign FLA7_IN = (FLASH_ADDR_BUS_OE[7] === 1'h1) ? FLASH_ADDR_BUS[7] : strap7;
  assign FLA1_IN = (FLASH_ADDR_BUS_OE[1] === 1'h1) ? FLASH_ADDR_BUS[1] : strap1;
  assign FLA14_IN = (FLASH_ADDR_BUS_OE[14] === 1'h1) ? FLASH_ADDR_BUS[14] : prom_do;
  assign FLASH_DATA_BUS_IN = (FLASH_DATA_BUS_OE === 1'h1) ? FLASH_DATA_BUS : flash_q;
  fsp_top uut (.CLK, .RST, .CE, .POWERUP_RESET_N, .ISOLATE_N, .OSC25, .FLASH_REQ, .FLASH_WRITE,
    .FLASH_ADDR, .FLASH_WDATA, .FLASH_ACK, .FLASH_RDATA, .INIT_WORD_VALID, .INIT_WORD_INDEX,
    .INIT_WORD_DATA, .INIT_DONE, .CLOCK_SELECT_STRAP, .AUX_POWER_STRAP, .FLA7_IN, .FLA1_IN,
    .FLA14_IN, .FLASH_ADDR_BUS, .FLASH_ADDR_BUS_OE, .FLASH_DATA_BUS_IN, .FLASH_DATA_BUS,
    .FLASH_DATA_BUS_OE, .SERIAL_PROM_SELECT, .FLASH_SELECT_N, .FLASH_READ_STROBE_N,
    .FLASH_WRITE_STROBE_N);
  fsp_partner u_part (.cs_n(FLASH_SELECT_N), .oe_n(FLASH_READ_STROBE_N),
    .we_n(FLASH_WRITE_STROBE_N), .addr(FLASH_ADDR_BUS), .data(FLASH_DATA_BUS_IN), .q(flash_q),
    .sel(SERIAL_PROM_SELECT), .sk(FLASH_ADDR_BUS[15]), .di(FLASH_ADDR_BUS[13]), .dout(prom_do));
  always #25 CLK = ~CLK;
  always @(posedge CLK) OSC25 <= ~OSC25;
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (failures == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic do_reset(logic s7, logic s1);
    strap7 <= s7;
    strap1 <= s1;
    RST <= 1'h1;
    repeat (10) @(posedge CLK);
    RST <= 1'h0;
    // Swap the pulls after release so a late capture would show.
    strap7 <= ~s7;
    strap1 <= ~s1;
    @(posedge CLK);
    check("clock strap", CLOCK_SELECT_STRAP, s7);
    check("power strap", AUX_POWER_STRAP, s1);
  endtask
  task automatic flash_op(logic wr, logic [16:0] a, logic [7:0] d, int lim);
    FLASH_REQ <= 1'h1;
    FLASH_WRITE <= wr;
    FLASH_ADDR <= a;
    FLASH_WDATA <= d;
    for (int i = 0; i < lim && FLASH_ACK !== 1'h1; i++) begin
      @(posedge CLK);
      if ((FLASH_READ_STROBE_N & FLASH_WRITE_STROBE_N) === 1'h0) check("addr", FLASH_ADDR_BUS, a);
    end
    FLASH_REQ <= 1'h0;
    check("ack", FLASH_ACK, 1'h1);
    check("done at ack", INIT_DONE, 1'h1);
    if (!wr) check("rdata", FLASH_RDATA, d);
    @(posedge CLK);
  endtask
  task automatic t_boot_load;
    fork
      for (int w = 0; w < PROM_WORDS; w++) begin
        for (int i = 0; i < 600 && INIT_WORD_VALID !== 1'h1; i++) @(posedge CLK);
        check("valid", INIT_WORD_VALID, 1'h1);
        check("index", INIT_WORD_INDEX, w);
        check("word", INIT_WORD_DATA, {4'hA, 6'(w), ~6'(w)});
        @(posedge CLK);
      end
      flash_op(1'h1, 17'h1FFFF, 8'h5A, 40000);
    join
    check("done", INIT_DONE, 1'h1);
    check("prom select", SERIAL_PROM_SELECT, 1'h0);
  endtask
  task automatic t_flash;
    flash_op(1'h1, 17'h00002, 8'hA5, 20);
    flash_op(1'h0, 17'h1FFFF, 8'h5A, 20);
    flash_op(1'h0, 17'h00002, 8'hA5, 20);
  endtask
  task automatic t_isolate;
    for (int k = 0; k < 2; k++) begin
      // The first pass isolates the port, the second pulls the power-up reset.
      if (k == 0) ISOLATE_N <= 1'h0;
      else POWERUP_RESET_N <= 1'h0;
      repeat (3) @(posedge CLK);
      check("isolated", {FLASH_ADDR_BUS_OE, FLASH_DATA_BUS_OE, INIT_DONE}, 19'h0);
      ISOLATE_N <= 1'h1;
      POWERUP_RESET_N <= 1'h1;
      repeat (4) @(posedge CLK);
      check("reload", SERIAL_PROM_SELECT, 1'h1);
    end
    check("power strap kept", AUX_POWER_STRAP, 1'h1);
  endtask
  task automatic t_aux_clock;
    do_reset(1'h1, 1'h0);
    repeat (4) begin
      @(posedge CLK);
      check("pin16", {FLASH_ADDR_BUS_OE[16], FLASH_ADDR_BUS[16]}, {1'h1, ~OSC25});
    end
  endtask
  initial begin
    @(posedge CLK);
    do_reset(1'h0, 1'h1);
    t_boot_load();
    t_flash();
    t_isolate();
    t_aux_clock();
    end_of_test();
  end
  initial begin
    #(45000 * 50);
    failures++;
    end_of_test();
  end
endmodule // fsp_top_tb
`default_nettype wire
